// *** rtl/smbsp_slave.sv ***
// smbus slave port: device end with address decode, pointer and ram
// assumes bus lines arrive asynchronously; strap held during boot
`timescale 1ns/10ps
module smbsp_slave (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// bus link
	smbsp_if.slave bus,
	// boot straps
	input wire logic [1:0] addr_select_pin,
	input wire logic addr_extend_bit,
	input wire logic config_done,
	// internally generated signals
	input wire logic power_on_request_internal,
	input wire logic mains_internal,
	// user side
	output logic addr_valid,
	output logic [6:0] own_addr,
	output logic [15:0] pointer,
	output logic wr_strobe,
	output logic [6:0] wr_addr,
	output logic [7:0] wr_data,
	output logic power_on_request,
	output logic mains_sense
);
	import smbsp_pkg::*;

	// ==========================================
	// line synchronisers and condition detect
	logic [2:0] scl_sy;
	logic [2:0] sda_sy;
	logic scl_f;
	logic sda_f;
	logic scl_q;
	logic sda_q;
	logic [2:0] pin_s0;
	logic [2:0] pin_s1;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			scl_sy <= 3'h7;
			sda_sy <= 3'h7;
		end else begin
			scl_sy <= {scl_sy[1:0], bus.scl};
			sda_sy <= {sda_sy[1:0], bus.sda};
		end
	end

	// filtered levels and their previous values
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			if (scl_sy[1] == scl_sy[2])
				scl_f <= scl_sy[2];
			if (sda_sy[1] == sda_sy[2])
				sda_f <= sda_sy[2];
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	wire scl_rise = scl_f & ~scl_q;
	wire scl_fall = ~scl_f & scl_q;
	wire start_cond = scl_f & scl_q & sda_q & ~sda_f; // RQ6 RQ16
	wire stop_cond = scl_f & scl_q & ~sda_q & sda_f; // RQ11

	// ==========================================
	// address latch at end of boot
	// select pin synchronised per bit; captured once when stable
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin_s0 <= 3'h0;
			pin_s1 <= 3'h0;
		end else begin
			pin_s0 <= {pin_s0[1:0], addr_select_pin[0]};
			pin_s1 <= {pin_s1[1:0], addr_select_pin[1]};
		end
	end

	wire pin_stable = (pin_s0[1] == pin_s0[2]) & (pin_s1[1] == pin_s1[2]);
	wire [1:0] pin_now = {pin_s1[2], pin_s0[2]};
	// low bits from pin state and extend bit
	wire [2:0] low_ext0 = (pin_now == PIN_GND) ? LOW_GND0 : (pin_now == PIN_VDD) ? LOW_VDD0 : LOW_FLT0;
	wire [2:0] low_ext1 = (pin_now == PIN_GND) ? LOW_GND1 : (pin_now == PIN_VDD) ? LOW_VDD1 : LOW_FLT1;
	wire [2:0] low_bits = addr_extend_bit ? low_ext1 : low_ext0; // RQ2

	// latched once after download; only a new reset changes it
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			addr_valid <= 1'b0;
			own_addr <= {ADDR_HIGH, LOW_GND0};
		end else if (config_done && !addr_valid && pin_stable) begin // RQ5 RQ22
			addr_valid <= 1'b1;
			own_addr <= {ADDR_HIGH, low_bits}; // RQ1
		end
	end

	// ==========================================
	// byte engine
	smbsp_slv_e state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic [1:0] byte_idx;
	logic rw;
	logic mack;
	logic [7:0] cmd;
	logic sda_oe_n;
	logic [7:0] ram [RAM_WORDS];

	wire [6:0] rx_addr = shreg[7:1];
	wire addr_hit = addr_valid & ((rx_addr == own_addr) | (rx_addr == {ADDR_HIGH, BCAST_LOW})); // RQ3
	wire cmd_is_ram = (cmd <= RAM_TOP);
	wire cmd_is_ee = (cmd == EE_HIGH0) | (cmd == EE_HIGH1);
	wire ee_ok = ({cmd, shreg} <= EE_TOP); // RQ17
	wire ptr_in_ram = (pointer[15:8] == 8'h00);
	wire [7:0] ram_rd = ptr_in_ram ? ram[pointer[6:0]] : EE_READ_FILL;
	wire byte_done = scl_fall & (bit_cnt == 4'h8); // RQ10
	wire data_write = byte_done & (state == S_RECV) & (byte_idx == 2'h2) & cmd_is_ram;

	// frame state; start and stop take priority over bit handling
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= S_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			tx <= 8'hFF;
			byte_idx <= 2'h0;
			rw <= 1'b0;
			mack <= 1'b0;
			cmd <= 8'h00;
			sda_oe_n <= 1'b1;
			pointer <= 16'h0000;
		end else if (start_cond) begin // RQ6 RQ16
			state <= S_RECV;
			bit_cnt <= 4'h0;
			byte_idx <= 2'h0;
			sda_oe_n <= 1'b1;
		end else if (stop_cond) begin // RQ14 RQ15
			state <= S_IDLE;
			sda_oe_n <= 1'b1;
		end else begin
			unique case (state)
				S_IDLE, S_SKIP: begin
					sda_oe_n <= 1'b1; // RQ9
				end
				S_RECV: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_f}; // RQ7
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_done) begin
						sda_oe_n <= 1'b0; // RQ8
						state <= S_RACK;
						if (byte_idx == 2'h0) begin
							rw <= shreg[0]; // RQ7
							if (!addr_hit) begin
								sda_oe_n <= 1'b1; // RQ9
								state <= S_SKIP;
							end
						end else if (byte_idx == 2'h1) begin
							cmd <= shreg; // RQ12
							if (shreg <= RAM_TOP)
								pointer <= {8'h00, shreg}; // RQ20
						end else if (byte_idx == 2'h2 && cmd_is_ee && ee_ok) begin
							pointer <= {cmd, shreg}; // RQ17
						end
					end
				end
				S_RACK: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (byte_idx != 2'h3)
							byte_idx <= byte_idx + 2'h1;
						if (rw) begin
							sda_oe_n <= ram_rd[7];
							tx <= {ram_rd[6:0], 1'b1};
							state <= S_SEND;
						end else begin
							sda_oe_n <= 1'b1;
							state <= S_RECV;
						end
					end
				end
				S_SEND: begin
					if (scl_fall) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == 4'h7) begin
							sda_oe_n <= 1'b1; // RQ15
							state <= S_SACK;
							if (ptr_in_ram && pointer[6:0] != RAM_TOP[6:0])
								pointer <= pointer + 16'h0001;
						end else begin
							sda_oe_n <= tx[7]; // RQ11
							tx <= {tx[6:0], 1'b1};
						end
					end
				end
				S_SACK: begin
					if (scl_rise) begin
						mack <= ~sda_f;
					end else if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (mack) begin
							sda_oe_n <= ram_rd[7];
							tx <= {ram_rd[6:0], 1'b1};
							state <= S_SEND;
						end else begin
							state <= S_SKIP; // RQ15
						end
					end
				end
			endcase
		end
	end

	// ==========================================
	// volatile registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < RAM_WORDS; i++)
				ram[i] <= RAM_RESET;
		end else if (data_write) begin
			ram[cmd[6:0]] <= shreg; // RQ21
		end
	end

	// write report to the user side, one pulse per stored byte
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_strobe <= 1'b0;
			wr_addr <= 7'h00;
			wr_data <= 8'h00;
		end else begin
			wr_strobe <= data_write;
			if (data_write) begin
				wr_addr <= cmd[6:0];
				wr_data <= shreg;
			end
		end
	end

	// override selects bus-written value over internal source
	wire [7:0] ovr = ram[OVR_REG];
	wire [7:0] sig = ram[SIG_REG];
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			power_on_request <= 1'b0;
			mains_sense <= 1'b0;
		end else begin
			power_on_request <= ovr[OVR_POWER_ON_REQUEST_BIT] ? sig[OVR_POWER_ON_REQUEST_BIT] : power_on_request_internal; // RQ18
			mains_sense <= ovr[OVR_MAINS_BIT] ? sig[OVR_MAINS_BIT] : mains_internal; // RQ18
		end
	end

	// open-drain data only; clock is never driven
	assign bus.s_sda_o = 1'b0; // RQ19
	assign bus.s_sda_oe_n = sda_oe_n;
endmodule

// *** rtl/smbsp_pkg.sv ***
// smbus slave port with broadcast: shared constants and state types
// assumes both ends run on one 40 MHz clock with active-low async reset
// How it works
// (RQ1) address is 1010 plus three derived bits
// (RQ2) six addresses from select pin and extend bit
// (RQ3) broadcast address 1010111 always answered too
// (RQ4) master sends only writes to broadcast
// (RQ5) extend bit latched once after configuration download
// (RQ6) sda falling while scl high starts transfer
// (RQ7) eight bits msb first, last is direction
// (RQ8) matching address acknowledged by pulling sda low
// (RQ9) mismatch leaves sda released until stop
// (RQ10) nine clocks per byte including acknowledge
// (RQ11) sda changes only while scl low
// (RQ12) first written byte is the command
// (RQ13) master sets pointer before any read
// (RQ14) master ends write with stop
// (RQ15) read ends with master nack then stop
// (RQ16) repeated start accepted in place of stop
// (RQ17) ram at 00h-7Fh, nonvolatile at 8000h-813Fh
// (RQ18) override bits route bus writes to signals
// (RQ19) device only slave, never drives clock
// (RQ20) command alone loads the register pointer
// (RQ21) command plus data writes volatile register
// (RQ22) select pin sampled once, address then fixed
package smbsp_pkg;
	// ==========================================
	// addressing
	localparam logic [3:0] ADDR_HIGH = 4'hA;
	localparam logic [2:0] BCAST_LOW = 3'h7;
	localparam logic [1:0] PIN_GND = 2'h0;
	localparam logic [1:0] PIN_VDD = 2'h1;
	localparam logic [2:0] LOW_GND0 = 3'h0;
	localparam logic [2:0] LOW_VDD0 = 3'h1;
	localparam logic [2:0] LOW_FLT0 = 3'h4;
	localparam logic [2:0] LOW_GND1 = 3'h2;
	localparam logic [2:0] LOW_VDD1 = 3'h3;
	localparam logic [2:0] LOW_FLT1 = 3'h5;
	// ==========================================
	// memory map
	localparam int RAM_WORDS = 128;
	localparam logic [7:0] RAM_TOP = 8'h7F;
	localparam logic [7:0] EE_HIGH0 = 8'h80;
	localparam logic [7:0] EE_HIGH1 = 8'h81;
	localparam logic [15:0] EE_TOP = 16'h813F;
	localparam logic [7:0] RAM_RESET = 8'h00;
	localparam logic [7:0] EE_READ_FILL = 8'hFF;
	localparam logic [6:0] OVR_REG = 7'h12;
	localparam logic [6:0] SIG_REG = 7'h13;
	localparam int OVR_POWER_ON_REQUEST_BIT = 0;
	localparam int OVR_MAINS_BIT = 1;
	// ==========================================
	// timing
	localparam int CLK_NS = 25;
	localparam int QUARTER_NS = 2500;
	localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
	// ==========================================
	// state types
	typedef enum logic [2:0] {S_IDLE, S_RECV, S_RACK, S_SEND, S_SACK, S_SKIP} smbsp_slv_e;
	typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} smbsp_mst_e;
endpackage

// *** rtl/smbsp_if.sv ***
// smbus slave port: the two-wire link joining master and slave ends
// assumes open-drain lines with pull-ups; enables are active low
`timescale 1ns/10ps
interface smbsp_if;
	logic m_scl_o;
	logic m_scl_oe_n;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic s_sda_o;
	logic s_sda_oe_n;
	logic scl;
	logic sda;
	// wired-and of the open-drain drivers, pulled high when released
	assign scl = m_scl_oe_n ? 1'b1 : m_scl_o;
	assign sda = (m_sda_oe_n ? 1'b1 : m_sda_o) & (s_sda_oe_n ? 1'b1 : s_sda_o);
	modport master (output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n, input scl, input sda);
	modport slave (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface

// *** rtl/smbsp_master.sv ***
// smbus slave port: master end generating clock, start and stop
// assumes same clock as slave; one request at a time on the user side
`timescale 1ns/10ps
module smbsp_master (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// bus link
	smbsp_if.master bus,
	// request
	input wire logic req_valid,
	input wire logic [6:0] req_addr,
	input wire logic req_read,
	input wire logic [1:0] req_nbytes,
	input wire logic [23:0] req_wdata,
	output logic req_ready,
	// answer
	output logic done,
	output logic nack,
	output logic [7:0] rd_data
);
	import smbsp_pkg::*;

	// ==========================================
	// quarter-bit tick divider
	logic [15:0] qdiv;
	wire tick = (qdiv == 16'(QUARTER_CYC - 1));
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			qdiv <= 16'h0000;
		else
			qdiv <= tick ? 16'h0000 : qdiv + 16'h0001;
	end

	// ==========================================
	// frame sequencer
	smbsp_mst_e state;
	logic [1:0] q;
	logic [3:0] bit_cnt;
	logic [7:0] tx_sh;
	logic [15:0] wbuf;
	logic [1:0] left;
	logic rd_phase;
	logic rd_req;
	logic scl_oe_n;
	logic sda_oe_n;

	// broadcast never read: a read request to it is sent as write
	wire bcast = (req_addr == {ADDR_HIGH, BCAST_LOW});
	wire rd_eff = req_read & ~bcast; // RQ4
	wire in_data = (bit_cnt != 4'h8);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= M_IDLE;
			q <= 2'h0;
			bit_cnt <= 4'h0;
			tx_sh <= 8'hFF;
			wbuf <= 16'h0000;
			left <= 2'h0;
			rd_phase <= 1'b0;
			rd_req <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			req_ready <= 1'b1;
			done <= 1'b0;
			nack <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			done <= 1'b0;
			if (state == M_IDLE) begin
				if (req_valid && req_ready) begin
					state <= M_START;
					req_ready <= 1'b0;
					q <= 2'h0;
					nack <= 1'b0;
					rd_req <= rd_eff;
					tx_sh <= {req_addr, rd_eff}; // RQ7
					wbuf <= req_wdata[23:8];
					rd_phase <= 1'b0;
					bit_cnt <= 4'h0;
					// a read carries no command: one data byte returned
					left <= rd_eff ? 2'h1 : req_nbytes; // RQ13
					sda_oe_n <= 1'b1;
					if (!rd_eff)
						tx_sh <= {req_addr, 1'b0};
				end
			end else if (tick) begin
				q <= q + 2'h1;
				unique case (state)
					M_START: begin
						if (q == 2'h1)
							sda_oe_n <= 1'b0; // RQ6
						if (q == 2'h2)
							scl_oe_n <= 1'b0;
						if (q == 2'h3)
							state <= M_BIT;
					end
					M_BIT: begin
						unique case (q)
							2'h0: sda_oe_n <= (in_data && !rd_phase) ? tx_sh[7] : 1'b1; // RQ11 RQ15
							2'h1: scl_oe_n <= 1'b1;
							2'h2: begin
								if (in_data && rd_phase)
									rd_data <= {rd_data[6:0], bus.sda};
								if (!in_data && !rd_phase && bus.sda)
									nack <= 1'b1;
							end
							2'h3: begin
								scl_oe_n <= 1'b0;
								if (in_data) begin
									bit_cnt <= bit_cnt + 4'h1;
									tx_sh <= {tx_sh[6:0], 1'b1};
								end else if (nack || left == 2'h0 || rd_phase) begin
									state <= M_STOP; // RQ10 RQ14
								end else begin
									bit_cnt <= 4'h0;
									left <= left - 2'h1;
									rd_phase <= rd_req;
									// write bytes leave the buffer in order, first byte on top
									tx_sh <= rd_req ? 8'hFF : wbuf[15:8];
									wbuf <= {wbuf[7:0], 8'h00};
								end
							end
						endcase
					end
					M_STOP: begin
						if (q == 2'h0)
							sda_oe_n <= 1'b0;
						if (q == 2'h1)
							scl_oe_n <= 1'b1;
						if (q == 2'h2)
							sda_oe_n <= 1'b1; // RQ14
						if (q == 2'h3) begin
							state <= M_IDLE;
							done <= 1'b1;
							req_ready <= 1'b1;
						end
					end
					default: state <= M_IDLE;
				endcase
			end
		end
	end

	// open-drain drivers straight from the sequencer flops
	assign bus.m_scl_o = 1'b0;
	assign bus.m_scl_oe_n = scl_oe_n;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_sda_oe_n = sda_oe_n;
endmodule

// *** test/smbsp_asserts.sv ***
// smbus slave port: assertions on the two-wire link between both ends
// assumes tb instantiates it beside the link interface, one clock domain
`timescale 1ns/10ps
module smbsp_asserts (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// master drivers
	input wire logic m_scl_o,
	input wire logic m_scl_oe_n,
	input wire logic m_sda_o,
	input wire logic m_sda_oe_n,
	// slave drivers
	input wire logic s_sda_o,
	input wire logic s_sda_oe_n,
	// resolved lines
	input wire logic scl,
	input wire logic sda
);
	logic [3:0] rises;
	logic [7:0] shreg;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// ==========================================
	// clock rises and shifted bits since the last start
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rises <= 4'h0;
			shreg <= 8'h00;
		end else if (scl && $fell(sda)) begin
			rises <= 4'h0;
		end else if ($rose(scl)) begin
			rises <= (rises == 4'hF) ? rises : rises + 4'h1;
			shreg <= {shreg[6:0], sda};
		end
	end
	// ==========================================
	// acknowledge steps: driven after the eighth bit, still low in the ninth high
	sequence ack_start;
		$fell(s_sda_oe_n) && rises == 4'h8;
	endsequence
	sequence ack_high;
		##[150:250] (scl && !s_sda_oe_n);
	endsequence
	slv_drain_a: assert property (!s_sda_oe_n |-> !s_sda_o) else $error("slave drives sda high");
	mst_drain_a: assert property (!m_scl_oe_n |-> !m_scl_o) else $error("scl driven high");
	mst_sda_drain_a: assert property (!m_sda_oe_n |-> !m_sda_o) else $error("master drives sda high");
	ack_ninth_a: assert property (ack_start |-> ack_high) else $error("ack not held into ninth clock");
	ack_hold_a: assert property ($rose(scl) && !s_sda_oe_n |-> (!s_sda_oe_n)[*8]) else $error("sda moved in high");
	ack_slot_a: assert property ($fell(s_sda_oe_n) && rises < 4'h9 |-> rises == 4'h8) else $error("ack in wrong slot");
	ack_addr_a: assert property (ack_start |-> shreg[7:4] == 4'hA) else $error("ack for foreign address");
	drive_low_a: assert property ($fell(s_sda_oe_n) |-> !scl && $past(scl, 20)) else $error("drive not after fall");
	free_low_a: assert property ($rose(s_sda_oe_n) |-> !scl) else $error("sda released while scl high");
	start_hold_a: assert property (scl && $fell(sda) |-> scl[*8]) else $error("scl not high after start");
endmodule

// *** test/tb.sv ***
// smbus slave port: self-checking bench joining master and slave ends
// assumes the package timing as is; straps change across resets and once after the last latch
`timescale 1ns/10ps
module tb;
	import smbsp_pkg::*;
	logic clock, resetn, addr_extend_bit, config_done, power_on_request_internal, mains_internal;
	logic [1:0] addr_select_pin, req_nbytes;
	logic addr_valid, wr_strobe, power_on_request, mains_sense;
	logic [6:0] own_addr, wr_addr, req_addr;
	logic [15:0] pointer;
	logic [7:0] wr_data, rd_data;
	logic req_valid, req_read, req_ready, done, nack;
	logic [23:0] req_wdata;
	int miscompares, checks, strobes, i;
	// strap rows: pin, extend bit, expected low address bits
	logic [5:0] rows [6] = '{6'h00, 6'h11, 6'h24, 6'h0A, 6'h1B, 6'h3D};
	// ==========================================
	// link and both ends
	smbsp_if link();
	smbsp_slave i_smbsp_slave (.clock(clock), .resetn(resetn), .bus(link), .addr_select_pin(addr_select_pin),
		.addr_extend_bit(addr_extend_bit), .config_done(config_done), .power_on_request_internal(power_on_request_internal),
		.mains_internal(mains_internal), .addr_valid(addr_valid), .own_addr(own_addr), .pointer(pointer),
		.wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .power_on_request(power_on_request),
		.mains_sense(mains_sense));
	smbsp_master i_smbsp_master (.clock(clock), .resetn(resetn), .bus(link), .req_valid(req_valid),
		.req_addr(req_addr), .req_read(req_read), .req_nbytes(req_nbytes), .req_wdata(req_wdata),
		.req_ready(req_ready), .done(done), .nack(nack), .rd_data(rd_data));
	smbsp_asserts i_smbsp_asserts (.clock(clock), .resetn(resetn), .m_scl_o(link.m_scl_o),
		.m_scl_oe_n(link.m_scl_oe_n), .m_sda_o(link.m_sda_o), .m_sda_oe_n(link.m_sda_oe_n),
		.s_sda_o(link.s_sda_o), .s_sda_oe_n(link.s_sda_oe_n), .scl(link.scl), .sda(link.sda));
	// ==========================================
	// clock and stored-byte counter
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) if (wr_strobe === 1'b1) strobes++;
	// ==========================================
	// compare, verdict, reset and transfer tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic boot(input logic [1:0] pin, input logic ext);
		int k;
		resetn = 1'b0;
		config_done = 1'b0;
		addr_select_pin = pin;
		addr_extend_bit = ext;
		repeat (3) @(posedge clock);
		#2 resetn = 1'b1;
		check({15'h0000, addr_valid}, 16'h0000);
		check(pointer, 16'h0000);
		check({14'h0000, link.scl, link.sda}, 16'h0003);
		repeat (2) @(posedge clock);
		#2 config_done = 1'b1;
		for (k = 0; k < 50 && addr_valid !== 1'b1; k++) begin
			@(posedge clock);
			#2;
		end
		if (k == 50) miscompares++;
		if (k == 50) print_verdict();
		@(posedge clock);
		#2;
	endtask
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [1:0] n, input logic [15:0] w);
		int k;
		req_addr = a;
		req_read = rd;
		req_nbytes = n;
		req_wdata = {w, 8'h00};
		req_valid = 1'b1;
		@(posedge clock);
		#2 req_valid = 1'b0;
		check({15'h0000, req_ready}, 16'h0000);
		for (k = 0; k < 20000 && done !== 1'b1; k++) begin
			@(posedge clock);
			#2;
		end
		if (k == 20000) miscompares++;
		if (k == 20000) print_verdict();
		check({15'h0000, req_ready}, 16'h0001);
	endtask
	// ==========================================
	// main sequence
	initial begin
		resetn = 1'b0;
		{req_valid, req_read, req_nbytes, req_addr, req_wdata} = '0;
		{power_on_request_internal, mains_internal} = 2'h2;
		for (i = 0; i < 6; i++) begin
			boot(rows[i][5:4], rows[i][3]);
			check({9'h000, own_addr}, {9'h000, ADDR_HIGH, rows[i][2:0]});
			xfer({ADDR_HIGH, rows[i][2:0]}, 1'b0, 2'h0, 16'h0000);
			check({15'h0000, nack}, 16'h0000);
		end
		// straps moved after latching leave the address alone
		addr_extend_bit = 1'b0;
		addr_select_pin = 2'h0;
		repeat (8) @(posedge clock);
		#2;
		check({9'h000, own_addr}, 16'h0055);
		check({14'h0000, power_on_request, mains_sense}, 16'h0002);
		// broadcast store, then override through a direct store
		xfer(7'h57, 1'b0, 2'h2, 16'h1302);
		check({15'h0000, nack}, 16'h0000);
		check({1'b0, wr_addr, wr_data}, 16'h1302);
		xfer(7'h55, 1'b0, 2'h2, 16'h1203);
		check({1'b0, wr_addr, wr_data}, 16'h1203);
		repeat (4) @(posedge clock);
		#2;
		check({14'h0000, power_on_request, mains_sense}, 16'h0001);
		// foreign address is refused and stores nothing
		xfer(7'h54, 1'b0, 2'h1, 16'h2000);
		check({15'h0000, nack}, 16'h0001);
		check(strobes[15:0], 16'h0002);
		// command alone sets the pointer, read returns that register
		xfer(7'h55, 1'b0, 2'h1, 16'h1300);
		check(pointer, 16'h0013);
		xfer(7'h55, 1'b1, 2'h0, 16'h0000);
		check({7'h00, nack, rd_data}, 16'h0002);
		// a read asked of the broadcast address goes out as a write
		xfer(7'h57, 1'b1, 2'h1, 16'h1100);
		check(pointer, 16'h0011);
		check({7'h00, nack, rd_data}, 16'h0002);
		// nonvolatile pointer at the top of the map
		xfer(7'h55, 1'b0, 2'h2, 16'h813F);
		check(pointer, EE_TOP);
		print_verdict();
	end
endmodule
